// ==== core/sfcp_core.sv ====
/*
 Command front end of a serial flash: framing, opcode decode, protection.
 Assumes a flash core on clk that runs each started operation and
 pulses op_done, and an array read port answering mem_rdata for
 mem_addr within half a link clock period.
*/
//
// Operation
// R01: After reset the command machine sits in standby.
// R02: Data-changing frames must end on a whole byte.
// R03: Host sets the write latch first; writes refused while it is clear.
// R04: Protect level selects a lower region that cannot be changed.
// R05: Write-protect pin low with status lock blocks protect bit changes.
// R06: In deep sleep only the wake opcode is obeyed.
// R07: Bits travel MSB first, sampled on rising link clock.
// R08: Each frame opens with one opcode byte, then address or data.
// R09: Host deselects right after the last bit of a write frame.
// R10: Read frames output data after input; host ends by deselecting.
// R11: Write-type commands run only on a multiple of eight clocks.
// R12: Program ending in a partial byte does nothing, latch stays set.
// R13: Status read low or high byte continuously; status write opcodes.
// R14: Latch clear opcode; volatile enable opcode for next status write.
// R15: Plain read after address; fast read after address and dummy.
// R16: Dual read sends odd bits on line 1, even on line 0.
// R17: Page, 4K, half block and block erase take three address bytes.
// R18: Either chip erase opcode erases all, no address.
// R19: Security erase, program and read opcodes.
// R20: Security address: top byte zero, register select, middle zero.
// R21: Identification reads return maker and device codes.
// R22: Unknown opcode: stay standby, output released.
// R23: Write latch clears at reset and when operations finish.
// R24: Busy bit is one while an operation runs.
// R25: Address bits above the array size are ignored.
// R26: Reset enable then reset returns the machine to standby.
`default_nettype none
module sfcp_core #(
    parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
    parameter logic [7:0] DEV_CODE = 8'h3c, // Arbitrary value
    parameter logic [15:0] ID_WORD = 16'h1234 // Arbitrary value
) (
    // System
    input wire logic clk,
    input wire logic rst,
    // Serial link pins
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic dual_line_0_i,
    input wire logic dual_line_1_i,
    output logic dual_line_0_o,
    output logic dual_line_0_oe,
    output logic dual_line_1_o,
    output logic dual_line_1_oe,
    input wire logic write_protect_n,
    // Array port on the link clock
    output logic [18:0] mem_addr,
    output logic mem_space,
    output logic [7:0] prog_data,
    output logic prog_we,
    input wire logic [7:0] mem_rdata,
    // Operation port on clk
    output logic op_start,
    output sfcp_pkg::sfcp_op_t op_kind,
    output logic [23:0] op_addr,
    input wire logic op_done,
    // Status
    output logic [15:0] status_word,
    output logic deep_sleep
);

////////////////////////////////////////////////////////////////////////
// Opcode matches
logic [7:0] opc_reg;
wire c_rlo = opc_reg == sfcp_pkg::OP_RD_ST_LO;
wire c_rhi = opc_reg == sfcp_pkg::OP_RD_ST_HI;
wire c_rd = opc_reg == sfcp_pkg::OP_READ;
wire c_frd = opc_reg == sfcp_pkg::OP_FREAD;
wire c_drd = opc_reg == sfcp_pkg::OP_DREAD;
wire c_srd = opc_reg == sfcp_pkg::OP_SEC_RD;
wire c_ido = opc_reg == sfcp_pkg::OP_ID_OLD;
wire c_id = opc_reg == sfcp_pkg::OP_ID;
wire c_wake = opc_reg == sfcp_pkg::OP_WAKE;
wire c_prg = opc_reg == sfcp_pkg::OP_PROG;
wire c_sprg = opc_reg == sfcp_pkg::OP_SEC_PRG;
wire c_sers = opc_reg == sfcp_pkg::OP_SEC_ERS;
wire c_wst = opc_reg == sfcp_pkg::OP_WR_ST;
wire c_wsth = opc_reg == sfcp_pkg::OP_WR_ST_HI;
wire c_epg = opc_reg == sfcp_pkg::OP_ERS_PG;
wire c_e4k = opc_reg == sfcp_pkg::OP_ERS_4K;
wire c_e32 = opc_reg == sfcp_pkg::OP_ERS_32K;
wire c_e64 = opc_reg == sfcp_pkg::OP_ERS_64K;
wire c_eall = opc_reg == sfcp_pkg::OP_ERS_ALL_A ||
    opc_reg == sfcp_pkg::OP_ERS_ALL_B;

////////////////////////////////////////////////////////////////////////
// Link domain: frame capture
logic fresh_reg;
logic frm_tgl_reg;
logic [15:0] cnt_reg;
logic [15:0] cnt_next;
logic [6:0] sh_reg;
logic [23:0] addr_reg;
logic [1:0] id_idx_reg;
logic [16:0] st_m_reg;
logic [16:0] st_l_reg;
logic [15:0] hdr_len;
logic [15:0] ob;
logic [15:0] obn;
logic [7:0] src;

// Set while select is high, so the first rising edge restarts counts
always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
        fresh_reg <= 1'b1;
    end else begin
        fresh_reg <= 1'b0;
    end
end

// R07: MSB-first shift
wire [7:0] sh_next = {sh_reg, dual_line_0_i};
assign cnt_next = fresh_reg ? 16'h0001 :
    (&cnt_reg) ? cnt_reg : cnt_reg + 16'h0001;
wire byte_end = cnt_next[2:0] == 3'h0;
wire [23:0] addr_next = (cnt_next > sfcp_pkg::LEN_OPC &&
    cnt_next <= sfcp_pkg::LEN_ADDR) ? {addr_reg[22:0], dual_line_0_i} :
    addr_reg;
wire sleep_l = st_l_reg[16];
wire busy_l = st_l_reg[sfcp_pkg::ST_BUSY];

// R15: header length per read opcode
assign hdr_len = (c_rlo || c_rhi || c_id) ? sfcp_pkg::LEN_OPC :
    (c_rd || c_ido || c_wake) ? sfcp_pkg::LEN_ADDR :
    (c_frd || c_drd || c_srd) ? sfcp_pkg::LEN_DUMMY :
    sfcp_pkg::LEN_NONE;
// R06: only the wake read while asleep; array reads refused while busy
wire rd_allow = sleep_l ? c_wake :
    !(busy_l && (c_rd || c_frd || c_drd || c_srd));
// R22: unknown opcode leaves the output released
wire rd_ok = rd_allow && hdr_len != sfcp_pkg::LEN_NONE;
wire out_on = rd_ok && !fresh_reg && cnt_reg >= hdr_len;
assign ob = cnt_reg - hdr_len;
assign obn = cnt_next - hdr_len;
wire adv = rd_ok && cnt_next > hdr_len &&
    (c_drd ? obn[1:0] == 2'h0 : obn[2:0] == 3'h0);

// R21: identification byte sequence
wire [7:0] id_byte = id_idx_reg == 2'h0 ? MAKER_CODE :
    id_idx_reg == 2'h1 ? ID_WORD[15:8] : ID_WORD[7:0];
// R13: status bytes; R21: codes; otherwise array data
assign src = c_rlo ? st_l_reg[7:0] : c_rhi ? st_l_reg[15:8] :
    c_id ? id_byte : c_ido ? (mem_addr[0] ? DEV_CODE : MAKER_CODE) :
    c_wake ? DEV_CODE : mem_rdata;
wire [2:0] bit_s = 3'h7 - ob[2:0];
// R16: odd bits on line 1, even bits on line 0
wire [2:0] bit_h = {~ob[1:0], 1'b1};
wire [2:0] bit_l = {~ob[1:0], 1'b0};

always_ff @(posedge spi_sclk or posedge rst) begin
    if (rst) begin
        cnt_reg <= '0;
        sh_reg <= '0;
        opc_reg <= '0;
        addr_reg <= '0;
        frm_tgl_reg <= 1'b0;
        st_m_reg <= '0;
        st_l_reg <= '0;
    end else begin
        cnt_reg <= cnt_next;
        sh_reg <= sh_next[6:0];
        addr_reg <= addr_next;
        st_m_reg <= {deep_sleep, status_word};
        st_l_reg <= st_m_reg;
        if (fresh_reg) begin
            frm_tgl_reg <= ~frm_tgl_reg;
        end
        // R08: the first byte is the opcode
        if (cnt_next == sfcp_pkg::LEN_OPC) begin
            opc_reg <= sh_next;
        end
    end
end

// Array address, identification index and program strobes
always_ff @(posedge spi_sclk or posedge rst) begin
    if (rst) begin
        mem_addr <= '0;
        mem_space <= 1'b0;
        id_idx_reg <= 2'h0;
        prog_we <= 1'b0;
        prog_data <= '0;
    end else begin
        // R25: only the low array address bits are kept
        if (cnt_next == sfcp_pkg::LEN_ADDR) begin
            mem_addr <= addr_next[18:0];
            mem_space <= c_srd || c_sprg || c_sers;
        end else if (adv) begin
            mem_addr <= mem_addr + 19'h00001;
        end else if (prog_we) begin
            mem_addr <= {mem_addr[18:8], mem_addr[7:0] + 8'h01};
        end
        if (cnt_next == sfcp_pkg::LEN_OPC) begin
            id_idx_reg <= 2'h0;
        end else if (adv) begin
            id_idx_reg <= id_idx_reg == 2'h2 ? 2'h0 : id_idx_reg + 2'h1;
        end
        prog_we <= (c_prg || c_sprg) && byte_end &&
            cnt_next > sfcp_pkg::LEN_ADDR;
        prog_data <= sh_next;
    end
end

// R10: data leaves on the falling edge, released on deselect
always_ff @(negedge spi_sclk or posedge spi_cs_n or posedge rst) begin
    if (rst || spi_cs_n) begin
        dual_line_0_o <= 1'b0;
        dual_line_0_oe <= 1'b0;
        dual_line_1_o <= 1'b0;
        dual_line_1_oe <= 1'b0;
    end else begin
        dual_line_1_oe <= out_on;
        dual_line_0_oe <= out_on && c_drd;
        dual_line_1_o <= c_drd ? src[bit_h] : src[bit_s];
        dual_line_0_o <= src[bit_l];
    end
end

////////////////////////////////////////////////////////////////////////
// System domain: pin synchronisers and frame end
logic [1:0] pin_s1_reg;
logic [1:0] pin_s2_reg;
logic [1:0] pin_s3_reg;
logic [1:0] pin_st_reg;
logic tg1_reg;
logic tg2_reg;
logic tdone_reg;
wire [1:0] pin_st_next = (pin_s2_reg & pin_s3_reg) |
    (pin_st_reg & (pin_s2_reg | pin_s3_reg));

always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
        pin_s1_reg <= 2'h3;
        pin_s2_reg <= 2'h3;
        pin_s3_reg <= 2'h3;
        pin_st_reg <= 2'h3;
        tg1_reg <= 1'b0;
        tg2_reg <= 1'b0;
    end else begin
        pin_s1_reg <= {spi_cs_n, write_protect_n};
        pin_s2_reg <= pin_s1_reg;
        pin_s3_reg <= pin_s2_reg;
        pin_st_reg <= pin_st_next;
        tg1_reg <= frm_tgl_reg;
        tg2_reg <= tg1_reg;
    end
end

// R09: the frame is judged only once select is back high
wire end_evt = pin_st_next[1] && !pin_st_reg[1];
wire exec = end_evt && tg2_reg != tdone_reg;

////////////////////////////////////////////////////////////////////////
// System domain: command execution
sfcp_pkg::sfcp_state_t state_reg;
sfcp_pkg::sfcp_state_t state_next;
sfcp_pkg::sfcp_op_t kind_next;
logic latch_reg;
logic lock_reg;
logic vol_reg;
logic rsten_reg;
logic [2:0] bp_reg;
logic [1:0] lb_reg;
logic [15:0] st_next;

wire sb = state_reg == sfcp_pkg::ST_STANDBY;
wire busy = state_reg == sfcp_pkg::ST_BUSYOP;
wire awake = state_reg != sfcp_pkg::ST_SLEEP;
wire len8 = cnt_reg == sfcp_pkg::LEN_OPC;
wire lena = cnt_reg == sfcp_pkg::LEN_ADDR;
wire lenp = cnt_reg > sfcp_pkg::LEN_ADDR;
// R02 R12: whole bytes only
wire byte_ok = cnt_reg[2:0] == 3'h0;
// R04: lower region protected by level
wire prot_hit = {1'b0, addr_reg[18:0]} < sfcp_pkg::PROT_TOP[bp_reg];
// R05: pin low with status lock freezes protect bits
wire hw_lock = lock_reg && !pin_st_reg[0];
// R20: security register address check and lock bits
wire sec_ok = addr_reg[23:16] == sfcp_pkg::SEC_HI &&
    addr_reg[11:8] == sfcp_pkg::SEC_MID &&
    ((addr_reg[15:12] == sfcp_pkg::SEC_SEL1 && !lb_reg[0]) ||
    (addr_reg[15:12] == sfcp_pkg::SEC_SEL2 && !lb_reg[1]));
// R17: erase units
wire is_ers = (c_epg || c_e4k || c_e32 || c_e64) && lena && !prot_hit;
// R18: chip erase only with nothing protected
wire is_all = c_eall && len8 && bp_reg == 3'h0;
wire is_prg = c_prg && lenp && !prot_hit;
// R19: security erase and program
wire is_sers = c_sers && lena && sec_ok;
wire is_sprg = c_sprg && lenp && sec_ok;
// R13: status write lengths
wire is_wrs = ((c_wst && (cnt_reg == sfcp_pkg::LEN_ST1 ||
    cnt_reg == sfcp_pkg::LEN_ST2)) ||
    (c_wsth && cnt_reg == sfcp_pkg::LEN_ST1)) && !hw_lock;
// R03 R11: latch set, standby and byte boundary needed
wire go = exec && sb && latch_reg && byte_ok && (is_ers || is_all ||
    is_prg || is_sers || is_sprg || (is_wrs && !vol_reg));
// R14: volatile status write needs no latch and no busy time
wire vol_go = exec && sb && byte_ok && vol_reg && is_wrs;
wire st_go = (go && is_wrs) || vol_go;
wire [7:0] st_lo = cnt_reg == sfcp_pkg::LEN_ST1 ? addr_reg[7:0] :
    addr_reg[15:8];
wire wr_hi = c_wsth || cnt_reg == sfcp_pkg::LEN_ST2;
// R26: reset only right after reset enable
wire rst_go = exec && awake && len8 && rsten_reg &&
    opc_reg == sfcp_pkg::OP_RST;
wire latch_set = exec && awake && len8 &&
    opc_reg == sfcp_pkg::OP_LATCH_SET;
// R14 R23: latch clear paths
wire latch_clr = rst_go || (busy && op_done) || (exec && awake && len8 &&
    opc_reg == sfcp_pkg::OP_LATCH_CLR);
wire [23:0] op_addr_next = (is_sers || is_sprg) ? addr_reg :
    {5'h00, addr_reg[18:0]};

assign kind_next = is_prg ? sfcp_pkg::OPK_PROG :
    is_sprg ? sfcp_pkg::OPK_SEC_PRG : is_sers ? sfcp_pkg::OPK_SEC_ERS :
    is_all ? sfcp_pkg::OPK_ERS_ALL : is_wrs ? sfcp_pkg::OPK_WR_ST :
    c_epg ? sfcp_pkg::OPK_ERS_PG : c_e4k ? sfcp_pkg::OPK_ERS_4K :
    c_e32 ? sfcp_pkg::OPK_ERS_32K : sfcp_pkg::OPK_ERS_64K;

// R06: asleep, only the wake opcode acts
assign state_next = rst_go ? sfcp_pkg::ST_STANDBY :
    (!awake && exec && c_wake) ? sfcp_pkg::ST_STANDBY :
    go ? sfcp_pkg::ST_BUSYOP :
    (exec && sb && len8 && opc_reg == sfcp_pkg::OP_SLEEP) ?
    sfcp_pkg::ST_SLEEP :
    (busy && op_done) ? sfcp_pkg::ST_STANDBY : state_reg;

// R24: busy bit follows the running operation
always_comb begin
    st_next = '0;
    st_next[sfcp_pkg::ST_BUSY] = busy;
    st_next[sfcp_pkg::ST_LATCH] = latch_reg;
    st_next[sfcp_pkg::ST_BP +: 3] = bp_reg;
    st_next[sfcp_pkg::ST_LOCK] = lock_reg;
    st_next[sfcp_pkg::ST_LB +: 2] = lb_reg;
end

// R01: standby and cleared latch after reset
always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
        state_reg <= sfcp_pkg::ST_STANDBY;
        latch_reg <= 1'b0;
        vol_reg <= 1'b0;
        rsten_reg <= 1'b0;
        tdone_reg <= 1'b0;
    end else begin
        state_reg <= state_next;
        latch_reg <= latch_set || (latch_reg && !latch_clr);
        if (exec) begin
            tdone_reg <= tg2_reg;
        end
        if (exec && awake) begin
            vol_reg <= len8 && opc_reg == sfcp_pkg::OP_VOL_EN;
            rsten_reg <= len8 && opc_reg == sfcp_pkg::OP_RST_EN;
        end
    end
end

always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
        bp_reg <= 3'h0;
        lock_reg <= 1'b0;
        lb_reg <= 2'h0;
        op_start <= 1'b0;
        op_kind <= sfcp_pkg::OPK_NONE;
        op_addr <= '0;
        status_word <= '0;
        deep_sleep <= 1'b0;
    end else begin
        op_start <= go;
        status_word <= st_next;
        deep_sleep <= !awake;
        if (go) begin
            op_kind <= kind_next;
            op_addr <= op_addr_next;
        end
        // R13: low byte sets protect and lock bits, high byte OTP bits
        if (st_go && !wr_hi) begin
            bp_reg <= st_lo[sfcp_pkg::ST_BP +: 3];
            lock_reg <= st_lo[sfcp_pkg::ST_LOCK];
        end else if (st_go && c_wst) begin
            bp_reg <= st_lo[sfcp_pkg::ST_BP +: 3];
            lock_reg <= st_lo[sfcp_pkg::ST_LOCK];
        end
        if (st_go && wr_hi) begin
            lb_reg <= lb_reg | addr_reg[sfcp_pkg::HI_LB +: 2];
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Assertions
default clocking cb @(posedge clk); endclocking
default disable iff (rst);

sequence s_busy_seen;
    busy ##1 status_word[sfcp_pkg::ST_BUSY];
endsequence
sequence s_sleep_cmd;
    !awake && exec && !c_wake;
endsequence

property p_boot;
    $fell(rst) |-> sb && !latch_reg;
endproperty
a_boot: assert property (p_boot) else $error("not standby"); // R01
property p_latch_set;
    latch_set |=> latch_reg;
endproperty
a_latch_set: assert property (p_latch_set) else $error("latch"); // R03
property p_refuse;
    exec && !latch_reg && !vol_reg |=> !op_start;
endproperty
a_refuse: assert property (p_refuse) else $error("no latch"); // R03
property p_len;
    exec && !busy && cnt_reg[2:0] != 3'h0 |=> !op_start ##1 !busy;
endproperty
a_len: assert property (p_len) else $error("bad length"); // R11
property p_partial;
    exec && c_prg && !byte_ok && latch_reg && !busy |=> latch_reg;
endproperty
a_partial: assert property (p_partial) else $error("latch lost"); // R12
property p_prot;
    exec && c_prg && prot_hit |=> !op_start;
endproperty
a_prot: assert property (p_prot) else $error("protected"); // R04
property p_wp;
    hw_lock |=> $stable(bp_reg) && $stable(lock_reg);
endproperty
a_wp: assert property (p_wp) else $error("locked bits moved"); // R05
property p_sleep;
    s_sleep_cmd |=> !awake && !op_start;
endproperty
a_sleep: assert property (p_sleep) else $error("woke"); // R06
property p_busy;
    go |=> s_busy_seen;
endproperty
a_busy: assert property (p_busy) else $error("busy bit"); // R24
property p_done;
    busy && op_done && !exec |=> sb && !latch_reg;
endproperty
a_done: assert property (p_done) else $error("done"); // R23
property p_rst;
    rst_go && !latch_set |=> sb && !latch_reg;
endproperty
a_rst: assert property (p_rst) else $error("soft reset"); // R26

endmodule
`default_nettype wire

// ==== core/sfcp_pkg.sv ====
/*
 Shared constants and types of the serial flash command front end.
 Assumes a byte-wide serial command stream with opcodes listed below.
*/
`default_nettype none
package sfcp_pkg;
    // Opcodes
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLR = 8'h04;
    localparam logic [7:0] OP_VOL_EN = 8'h50;
    localparam logic [7:0] OP_RD_ST_LO = 8'h05;
    localparam logic [7:0] OP_RD_ST_HI = 8'h35;
    localparam logic [7:0] OP_WR_ST = 8'h01;
    localparam logic [7:0] OP_WR_ST_HI = 8'h31;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FREAD = 8'h0b;
    localparam logic [7:0] OP_DREAD = 8'h3b;
    localparam logic [7:0] OP_ERS_PG = 8'h81;
    localparam logic [7:0] OP_ERS_4K = 8'h20;
    localparam logic [7:0] OP_ERS_32K = 8'h52;
    localparam logic [7:0] OP_ERS_64K = 8'hd8;
    localparam logic [7:0] OP_ERS_ALL_A = 8'hc7;
    localparam logic [7:0] OP_ERS_ALL_B = 8'h60;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_SEC_ERS = 8'h44;
    localparam logic [7:0] OP_SEC_PRG = 8'h42;
    localparam logic [7:0] OP_SEC_RD = 8'h48;
    localparam logic [7:0] OP_SLEEP = 8'hb9;
    localparam logic [7:0] OP_WAKE = 8'hab;
    localparam logic [7:0] OP_ID_OLD = 8'h90;
    localparam logic [7:0] OP_ID = 8'h9f;
    localparam logic [7:0] OP_RST_EN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;
    // Frame lengths in bits after select falls
    localparam logic [15:0] LEN_OPC = 16'h0008;
    localparam logic [15:0] LEN_ST1 = 16'h0010;
    localparam logic [15:0] LEN_ST2 = 16'h0018;
    localparam logic [15:0] LEN_ADDR = 16'h0020;
    localparam logic [15:0] LEN_DUMMY = 16'h0028;
    localparam logic [15:0] LEN_NONE = 16'hffff;
    // Status word layout
    localparam int ST_BUSY = 0;
    localparam int ST_LATCH = 1;
    localparam int ST_BP = 2;
    localparam int ST_LOCK = 7;
    localparam int ST_LB = 11;
    localparam int HI_LB = 3;
    // Exclusive top of the protected lower region per level
    localparam logic [19:0] PROT_TOP [8] = '{20'h00000, 20'h7e000,
        20'h7c000, 20'h78000, 20'h70000, 20'h60000, 20'h40000,
        20'h80000};
    // Security register address fields
    localparam logic [7:0] SEC_HI = 8'h00;
    localparam logic [3:0] SEC_SEL1 = 4'h1;
    localparam logic [3:0] SEC_SEL2 = 4'h2;
    localparam logic [3:0] SEC_MID = 4'h0;

    typedef enum logic [1:0] {ST_STANDBY, ST_BUSYOP, ST_SLEEP}
        sfcp_state_t;
    typedef enum logic [3:0] {OPK_NONE, OPK_PROG, OPK_ERS_PG, OPK_ERS_4K,
        OPK_ERS_32K, OPK_ERS_64K, OPK_ERS_ALL, OPK_SEC_ERS, OPK_SEC_PRG,
        OPK_WR_ST} sfcp_op_t;
endpackage
`default_nettype wire

// ==== sim/sfcp_host.sv ====
/*
 Host serial controller model: frames MSB-first bit streams.
 Assumes the bench resolves the returned line from the device enable.
*/
`default_nettype none
module sfcp_host (
    // Link pins
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic mosi,
    // Returned data
    input wire logic so_line,
    input wire logic so_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic saw_oe = 1'b0;
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        mosi = 1'b0;
    end
    task automatic xfer(input logic [63:0] tx, input int nbits,
            output logic [63:0] rx);
        rx = '0;
        saw_oe = 1'b0;
        #13 spi_cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            mosi = tx[63 - i];
            #32 spi_sclk = 1'b1;
            rx = {rx[62:0], so_line};
            saw_oe = saw_oe | so_oe;
            #32 spi_sclk = 1'b0;
        end
        #20 spi_cs_n = 1'b1;
        mosi = ~mosi;
        #150;
    endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
/*
 Self-checking bench of the command front end, with a flash core stub.
 Assumes the host model owns the link clock, still between frames.
*/
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b0;
    logic wp_n = 1'b1;
    logic [15:0] dual_rx = '0;
    logic op_done = 1'b0;
    logic flip = 1'b0;
    logic spi_sclk, spi_cs_n, mosi, so_line, l0_o, l0_oe, l1_o, l1_oe;
    logic mem_space, prog_we, op_start, deep_sleep;
    logic [18:0] mem_addr;
    logic [7:0] prog_data, mem_rdata;
    sfcp_pkg::sfcp_op_t op_kind, last_kind;
    logic [23:0] op_addr, last_addr;
    logic [15:0] status_word;
    logic [63:0] rx;
    int miscompares = 0;
    int cmp_count = 0;
    int starts = 0;
    always #5 clk = ~clk;
    always @(posedge clk) flip <= ~flip;
    // Released line shows a changing pattern
    assign so_line = l1_oe ? l1_o : flip;
    assign mem_rdata = mem_addr[7:0] ^ 8'h5c;
    // both lines taken on rising link clock
    always @(posedge spi_sclk) begin
        if (l0_oe === 1'b1) begin
            dual_rx <= {dual_rx[13:0], l1_o, l0_o};
        end
    end
    sfcp_host host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .mosi(mosi), .so_line(so_line), .so_oe(l1_oe));
    sfcp_core dut (.clk(clk), .rst(rst), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .dual_line_0_i(mosi), .dual_line_1_i(1'b0),
        .dual_line_0_o(l0_o), .dual_line_0_oe(l0_oe),
        .dual_line_1_o(l1_o), .dual_line_1_oe(l1_oe),
        .write_protect_n(wp_n), .mem_addr(mem_addr),
        .mem_space(mem_space), .prog_data(prog_data), .prog_we(prog_we),
        .mem_rdata(mem_rdata), .op_start(op_start), .op_kind(op_kind),
        .op_addr(op_addr), .op_done(op_done), .status_word(status_word),
        .deep_sleep(deep_sleep));
    ////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (op_start === 1'b1) begin
            starts <= starts + 1;
            last_kind <= op_kind;
            last_addr <= op_addr;
        end
    end
    // Flash core stub ends each operation after 20 cycles
    initial begin
        forever begin
            @(posedge op_start);
            repeat (20) @(posedge clk);
            #1 op_done = 1'b1;
            @(posedge clk);
            #1 op_done = 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op);
        host.xfer({op, 56'h0}, 8, rx);
    endtask
    function automatic logic latch();
        return status_word[sfcp_pkg::ST_LATCH];
    endfunction
    ////////////////////////////////////////////////////////////////////
    task automatic t_latch();
        check("status after reset", status_word, 32'h0);
        cmd(sfcp_pkg::OP_LATCH_SET);
        check("latch set", latch(), 1);
        host.xfer({sfcp_pkg::OP_RD_ST_LO, 56'h0}, 16, rx);
        check("status low byte", rx[7:0], 8'h02);
        check("read drove line", host.saw_oe, 1);
        cmd(sfcp_pkg::OP_LATCH_CLR);
        check("latch clear", latch(), 0);
        $display("test latch done");
    endtask
    task automatic t_erase();
        int s0;
        s0 = starts;
        host.xfer({8'h20, 24'hf12345, 32'h0}, 32, rx);
        check("erase without latch", starts, s0);
        cmd(sfcp_pkg::OP_LATCH_SET);
        host.xfer({8'h20, 24'h001000, 32'h0}, 33, rx);
        check("odd length erase", starts, s0);
        check("latch kept", latch(), 1);
        host.xfer({8'h20, 24'hf12345, 32'h0}, 32, rx);
        check("erase started", starts, s0 + 1);
        check("erase kind", last_kind, sfcp_pkg::OPK_ERS_4K);
        check("erase addr", last_addr, 24'h012345);
        check("busy set", status_word[sfcp_pkg::ST_BUSY], 1);
        repeat (30) @(posedge clk);
        #1 check("busy clear", status_word[sfcp_pkg::ST_BUSY], 0);
        check("latch cleared", latch(), 0);
        $display("test erase done");
    endtask
    task automatic t_read();
        host.xfer({8'h03, 24'h000010, 32'h0}, 48, rx);
        check("read data", rx[15:0], 16'h4c4d);
        host.xfer({8'hff, 56'h0}, 16, rx);
        check("unknown opcode line", host.saw_oe, 0);
        host.xfer({8'h3b, 24'h000010, 32'h0}, 48, rx);
        check("dual read", dual_rx, 16'h4c4d);
        host.xfer({8'h48, 24'h001003, 32'h0}, 48, rx);
        check("security read", rx[7:0], 8'h5f);
        check("security space", mem_space, 1);
        host.xfer({8'h9f, 56'h0}, 32, rx);
        check("identification", rx[23:0], 24'h5a1234);
        $display("test read done");
    endtask
    task automatic t_protect();
        int s0;
        cmd(sfcp_pkg::OP_LATCH_SET);
        host.xfer({8'h01, 8'h98, 48'h0}, 16, rx);
        repeat (30) @(posedge clk);
        #1 check("protect set", status_word, 16'h0098);
        s0 = starts;
        cmd(sfcp_pkg::OP_LATCH_SET);
        host.xfer({8'h20, 24'h030000, 32'h0}, 32, rx);
        check("protected erase", starts, s0);
        @(posedge clk);
        #1 wp_n = 1'b0;
        host.xfer({8'h01, 8'h00, 48'h0}, 16, rx);
        check("locked status", status_word, 16'h009a);
        @(posedge clk);
        #1 wp_n = 1'b1;
        cmd(sfcp_pkg::OP_VOL_EN);
        host.xfer({8'h01, 8'h00, 48'h0}, 16, rx);
        check("volatile write", status_word, 16'h0002);
        check("volatile no start", starts, s0);
        cmd(sfcp_pkg::OP_LATCH_CLR);
        $display("test protect done");
    endtask
    task automatic t_program();
        int s0;
        s0 = starts;
        cmd(sfcp_pkg::OP_LATCH_SET);
        host.xfer({8'h02, 24'h000100, 8'hff, 24'h0}, 44, rx);
        check("partial program", starts, s0);
        check("latch after partial", latch(), 1);
        host.xfer({8'h02, 24'h080105, 8'ha5, 24'h0}, 40, rx);
        check("program started", starts, s0 + 1);
        check("program kind", last_kind, sfcp_pkg::OPK_PROG);
        check("program addr", last_addr, 24'h000105);
        check("program strobe", prog_we, 1);
        check("program byte", prog_data, 8'ha5);
        check("program array addr", mem_addr, 19'h00105);
        repeat (30) @(posedge clk);
        #1 check("latch after program", latch(), 0);
        cmd(sfcp_pkg::OP_LATCH_SET);
        cmd(sfcp_pkg::OP_RST_EN);
        cmd(sfcp_pkg::OP_RST);
        check("soft reset latch", latch(), 0);
        cmd(sfcp_pkg::OP_LATCH_SET);
        cmd(sfcp_pkg::OP_RST_EN);
        cmd(sfcp_pkg::OP_VOL_EN);
        cmd(sfcp_pkg::OP_RST);
        check("cancelled reset", latch(), 1);
        cmd(sfcp_pkg::OP_LATCH_CLR);
        $display("test program done");
    endtask
    task automatic t_sleep();
        cmd(sfcp_pkg::OP_SLEEP);
        check("asleep", deep_sleep, 1);
        cmd(sfcp_pkg::OP_LATCH_SET);
        check("latch ignored asleep", latch(), 0);
        cmd(sfcp_pkg::OP_WAKE);
        check("awake", deep_sleep, 0);
        $display("test sleep done");
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        #1 rst = 1'b1;
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        t_latch();
        t_erase();
        t_protect();
        t_program();
        t_read();
        t_sleep();
        report_and_stop();
    end
    initial begin
        #500000;
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
